/* core/ocs_regs.sv */
/*
 * Oscillator control and status register file with clock switch control,
 * unlock protection, clock-fail flag and a maskable interrupt.
 * Assumes RST_I is the power-on reset and every input is synchronous to SYS_CLK_I.
 */
// Behaviour
// - Registers reset only by power-on reset.
// - Control writes need a preceding unlock.
// - Control shows source, PLL lock, failure.
// - Bits 10-8 hold requested new source.
// - Trim register tunes fast RC frequency.
// - Divisor register sets doze and scalers.
// - Feedback register sets main PLL multiply.
// - Aux control sets aux PLL scalers.
// - Aux feedback register for aux PLL.
// - Three-bit source codes fixed per table.
// - Request bit clears when switch completes.
// - Mode 1x blocks switching and monitor.
`timescale 1ns/1ps
`default_nettype none
module ocs_regs (
	// Clock and power-on reset.
	input  wire logic                     SYS_CLK_I,
	input  wire logic                     RST_I,
	// Avalon-MM slave.
	input  wire logic [ocs_pkg::AW-1:0]   AVS_ADDRESS_I,
	input  wire logic                     AVS_READ_I,
	input  wire logic                     AVS_WRITE_I,
	input  wire logic [ocs_pkg::DW-1:0]   AVS_WRITEDATA_I,
	input  wire logic [3:0]               AVS_BYTEENABLE_I,
	output logic      [ocs_pkg::DW-1:0]   AVS_READDATA_O,
	output logic                          AVS_WAITREQUEST_O,
	// Nonvolatile configuration.
	input  wire logic [ocs_pkg::SW-1:0]   INIT_SRC_I,
	input  wire logic [1:0]               SW_MON_MODE_I,
	// Oscillator status.
	input  wire logic                     PLL_LOCK_I,
	input  wire logic                     CLK_FAIL_I,
	input  wire logic                     SRC_READY_I,
	// Clock system controls.
	output logic      [ocs_pkg::SW-1:0]   SYS_SRC_O,
	output logic      [ocs_pkg::RW-1:0]   CLK_DIV_O,
	output logic      [ocs_pkg::RW-1:0]   PLL_FB_O,
	output logic      [ocs_pkg::RW-1:0]   RC_TRIM_O,
	output logic      [ocs_pkg::RW-1:0]   AUX_CTRL_O,
	output logic      [ocs_pkg::RW-1:0]   AUX_FB_O,
	output logic                          SEC_OSC_EN_O,
	output logic                          PIN_LOCK_O,
	// Interrupt.
	output logic                          IRQ_O
);
	typedef struct packed {
		logic                       wait_r;  // Waitrequest.
		logic [ocs_pkg::DW-1:0]     rdata;   // Read data.
		logic [ocs_pkg::SW-1:0]     cur;     // Current source.
		logic [ocs_pkg::SW-1:0]     nsrc;    // New source.
		logic                       lock;    // Switch lock.
		logic                       pinlk;   // Pin map lock.
		logic                       pllok;   // PLL locked.
		logic                       fail;    // Clock failure.
		logic                       sosc;    // Secondary enable.
		logic                       req;     // Switch request.
		logic [ocs_pkg::RW-1:0]     divisor; // Clock divisor.
		logic [ocs_pkg::RW-1:0]     pllfb;   // PLL feedback.
		logic [ocs_pkg::RW-1:0]     trim;    // RC trim.
		logic [ocs_pkg::RW-1:0]     auxc;    // Aux control.
		logic [ocs_pkg::RW-1:0]     auxfb;   // Aux feedback.
		ocs_pkg::ocs_key_t          key;     // Unlock progress.
		logic [ocs_pkg::IRQ_W-1:0]  irq_st;  // Sticky events.
		logic [ocs_pkg::IRQ_W-1:0]  irq_msk; // Event mask.
		logic                       irq;     // Interrupt level.
	} ocs_st_t;

	ocs_st_t st_q;       // Registered state.
	ocs_st_t st_d;       // Next state.
	ocs_sw_if sw ();     // Sequencer link.

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of the low half word, used by every writable register except the key and interrupt mask registers.
	function automatic logic [ocs_pkg::RW-1:0] wmerge(
		input logic [ocs_pkg::RW-1:0] old,
		input logic [ocs_pkg::DW-1:0] wd,
		input logic [3:0]             be
	);
		logic [ocs_pkg::RW-1:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// Read image of the switch control register; unused bits read zero.
	function automatic logic [ocs_pkg::RW-1:0] ctrl_img(input ocs_st_t s);
		logic [ocs_pkg::RW-1:0] r;
		r = '0;
		r[ocs_pkg::CUR_LSB +: ocs_pkg::SW] = s.cur;
		r[ocs_pkg::NEW_LSB +: ocs_pkg::SW] = s.nsrc;
		r[ocs_pkg::LOCK_BIT]  = s.lock;
		r[ocs_pkg::PINLK_BIT] = s.pinlk;
		r[ocs_pkg::PLLOK_BIT] = s.pllok;
		r[ocs_pkg::FAIL_BIT]  = s.fail;
		r[ocs_pkg::SOSC_BIT]  = s.sosc;
		r[ocs_pkg::REQ_BIT]   = s.req;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode helpers.
	logic                       rd_take; // Read sampled this edge.
	logic                       wr_acc;  // Write takes effect this edge.
	logic                       rd_acc;  // Read completes this edge.
	logic                       no_sw;   // Switching disabled by mode.
	logic [ocs_pkg::RW-1:0]     cw;      // Merged control write.
	assign rd_take = AVS_READ_I && st_q.wait_r;
	assign wr_acc  = AVS_WRITE_I && !st_q.wait_r;
	assign rd_acc  = AVS_READ_I && !st_q.wait_r;
	assign no_sw   = SW_MON_MODE_I[ocs_pkg::NOSW_BIT];
	assign cw      = wmerge(ctrl_img(st_q), AVS_WRITEDATA_I, AVS_BYTEENABLE_I);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic. Waitrequest drops one cycle after a request and rises
	// again after the accepting edge, so every access costs two cycles.
	always_comb begin
		st_d = st_q;
		st_d.wait_r = !((AVS_READ_I || AVS_WRITE_I) && st_q.wait_r);
		st_d.pllok = PLL_LOCK_I;
		// Read data is captured while waitrequest is still high.
		if (rd_take) begin
			if (AVS_ADDRESS_I == ocs_pkg::OFF_SWCTRL) begin
				st_d.rdata = {16'h0000, ctrl_img(st_q)};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_DIV) begin
				st_d.rdata = {16'h0000, st_q.divisor};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_PLLFB) begin
				st_d.rdata = {16'h0000, st_q.pllfb};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_TRIM) begin
				st_d.rdata = {16'h0000, st_q.trim};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_AUXC) begin
				st_d.rdata = {16'h0000, st_q.auxc};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_AUXFB) begin
				st_d.rdata = {16'h0000, st_q.auxfb};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_IRQST) begin
				st_d.rdata = {{(ocs_pkg::DW-ocs_pkg::IRQ_W){1'b0}}, st_q.irq_st};
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_IRQMSK) begin
				st_d.rdata = {{(ocs_pkg::DW-ocs_pkg::IRQ_W){1'b0}}, st_q.irq_msk};
			end else begin
				// Key and unmapped offsets read as zero.
				st_d.rdata = 32'h00000000;
			end
		end
		// A status read clears at its accepting edge; events below win.
		if (rd_acc && AVS_ADDRESS_I == ocs_pkg::OFF_IRQST) begin
			st_d.irq_st = '0;
		end
		// hardware ends the request on completion.
		if (sw.done) begin
			st_d.cur = sw.done_src;
			st_d.req = 1'b0;
			st_d.irq_st[ocs_pkg::EV_DONE] = 1'b1;
		end
		if (wr_acc) begin
			// Any write other than a key breaks the unlock sequence.
			st_d.key = ocs_pkg::KY_IDLE;
			if (AVS_ADDRESS_I == ocs_pkg::OFF_KEY) begin
				if (AVS_WRITEDATA_I[7:0] == ocs_pkg::KEY1) begin
					st_d.key = ocs_pkg::KY_ONE;
				end else if (st_q.key == ocs_pkg::KY_ONE &&
				             AVS_WRITEDATA_I[7:0] == ocs_pkg::KEY2) begin
					st_d.key = ocs_pkg::KY_OPEN;
				end
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_SWCTRL) begin
				if (st_q.key != ocs_pkg::KY_OPEN) begin
					st_d.irq_st[ocs_pkg::EV_DENY] = 1'b1;
				end else begin
					st_d.pinlk = cw[ocs_pkg::PINLK_BIT];
					st_d.sosc  = cw[ocs_pkg::SOSC_BIT];
					st_d.lock = st_q.lock | cw[ocs_pkg::LOCK_BIT];
					if (!cw[ocs_pkg::FAIL_BIT]) begin
						st_d.fail = 1'b0;
					end
					if (!st_q.lock) begin
						st_d.nsrc = cw[ocs_pkg::NEW_LSB +: ocs_pkg::SW];
					end
					if (cw[ocs_pkg::REQ_BIT] && !no_sw && !st_q.lock) begin
						st_d.req = 1'b1;
					end
				end
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_DIV) begin
				st_d.divisor = wmerge(st_q.divisor, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_PLLFB) begin
				st_d.pllfb = wmerge(st_q.pllfb, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_TRIM) begin
				st_d.trim = wmerge(st_q.trim, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_AUXC) begin
				st_d.auxc = wmerge(st_q.auxc, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_AUXFB) begin
				st_d.auxfb = wmerge(st_q.auxfb, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end else if (AVS_ADDRESS_I == ocs_pkg::OFF_IRQMSK) begin
				st_d.irq_msk = AVS_WRITEDATA_I[ocs_pkg::IRQ_W-1:0];
			end
		end
		if (CLK_FAIL_I && !no_sw) begin
			// failure sets, winning over a clear.
			st_d.fail = 1'b1;
			st_d.irq_st[ocs_pkg::EV_FAIL] = 1'b1;
		end
		st_d.irq = |(st_d.irq_st & st_d.irq_msk);
		if (RST_I) begin
			st_d = '0;
			st_d.wait_r = 1'b1;
			st_d.cur    = INIT_SRC_I;
			st_d.nsrc   = INIT_SRC_I;
			st_d.divisor = ocs_pkg::DIV_RST;
			// Lock status stays live through reset, so it is valid at release.
			st_d.pllok  = PLL_LOCK_I;
			st_d.pllfb  = ocs_pkg::ZERO_RST;
			st_d.key    = ocs_pkg::KY_IDLE;
		end
	end

	// One register holds the whole state.
	always_ff @(posedge SYS_CLK_I) begin
		st_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs are flop fields.
	assign AVS_READDATA_O    = st_q.rdata;
	assign AVS_WAITREQUEST_O = st_q.wait_r;
	assign SYS_SRC_O    = st_q.cur;
	assign CLK_DIV_O    = st_q.divisor;
	assign PLL_FB_O     = st_q.pllfb;
	assign RC_TRIM_O    = st_q.trim;
	assign AUX_CTRL_O   = st_q.auxc;
	assign AUX_FB_O     = st_q.auxfb;
	assign SEC_OSC_EN_O = st_q.sosc;
	assign PIN_LOCK_O   = st_q.pinlk;
	assign IRQ_O        = st_q.irq;
	assign sw.req       = st_q.req;
	assign sw.target    = st_q.nsrc;

	// The switch itself is sequenced in a small module of its own.
	ocs_switch_seq u_seq (
		.sys_clk_i   (SYS_CLK_I),
		.rst_i       (RST_I),
		.src_ready_i (SRC_READY_I),
		.sw          (sw.seq)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);

	a_por_strap_src: assert property (disable iff (1'b0)
		RST_I |=> (SYS_SRC_O == $past(INIT_SRC_I) && st_q.nsrc == $past(INIT_SRC_I)))
		else $error("reset did not load the strap");
	a_unlock_guard: assert property (
		(wr_acc && AVS_ADDRESS_I == ocs_pkg::OFF_SWCTRL && st_q.key != ocs_pkg::KY_OPEN)
		|=> $stable(st_q.nsrc) && $stable(st_q.lock) && st_q.irq_st[ocs_pkg::EV_DENY])
		else $error("locked control write took effect");
	a_pll_status: assert property (##1 st_q.pllok == $past(PLL_LOCK_I))
		else $error("PLL lock status stale");
	a_new_src_write: assert property (
		(wr_acc && AVS_ADDRESS_I == ocs_pkg::OFF_SWCTRL && st_q.key == ocs_pkg::KY_OPEN
		 && !st_q.lock && AVS_BYTEENABLE_I[1])
		|=> st_q.nsrc == $past(AVS_WRITEDATA_I[ocs_pkg::NEW_LSB +: ocs_pkg::SW]))
		else $error("new source not written");
	a_req_cleared: assert property ((sw.done && !wr_acc) |=> !st_q.req)
		else $error("request not cleared on completion");
	a_mode_no_switch: assert property ((no_sw && !st_q.req) |=> !st_q.req)
		else $error("switch accepted while disabled");
	a_mode_no_fail: assert property ((no_sw && !st_q.fail) |=> !st_q.fail)
		else $error("fail flag set while monitor off");
	a_cur_update: assert property (sw.done |=> SYS_SRC_O == $past(sw.done_src))
		else $error("current source not updated");
	a_fail_sticky: assert property ((st_q.fail && !wr_acc) |=> st_q.fail)
		else $error("fail flag dropped by itself");
	a_lock_sticky: assert property (st_q.lock |=> st_q.lock)
		else $error("switch lock cleared");
	a_wait_answer: assert property (((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O)
		|=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
		else $error("waitrequest timing wrong");
	a_irq_level: assert property (##1 IRQ_O == |(st_q.irq_st & st_q.irq_msk))
		else $error("interrupt level mismatch");

	c_switch_done: cover property (st_q.req ##[1:20] sw.done);
	c_fail_seen: cover property (CLK_FAIL_I && !no_sw);
	c_deny_seen: cover property ($rose(st_q.irq_st[ocs_pkg::EV_DENY]));
	c_irq_rise: cover property ($rose(IRQ_O));

endmodule // ocs_regs
`default_nettype wire

/* inc/ocs_pkg.sv */
/*
 * Shared constants and types of the oscillator control and status registers.
 * Assumes a 32-bit Avalon-MM slave with byte addresses on a six-bit address bus.
 */
package ocs_pkg;

	// Bus, register and source code widths.
	localparam int AW = 6;
	localparam int DW = 32;
	localparam int RW = 16;
	localparam int SW = 3;

	// Register byte offsets.
	localparam logic [AW-1:0] OFF_SWCTRL = 6'h00;
	localparam logic [AW-1:0] OFF_DIV    = 6'h04;
	localparam logic [AW-1:0] OFF_PLLFB  = 6'h08;
	localparam logic [AW-1:0] OFF_TRIM   = 6'h0c;
	localparam logic [AW-1:0] OFF_AUXC   = 6'h10;
	localparam logic [AW-1:0] OFF_AUXFB  = 6'h14;
	localparam logic [AW-1:0] OFF_KEY    = 6'h18;
	localparam logic [AW-1:0] OFF_IRQST  = 6'h1c;
	localparam logic [AW-1:0] OFF_IRQMSK = 6'h20;

	// Field positions of the switch control register, and the no-switch bit of the mode input.
	localparam int CUR_LSB   = 12;
	localparam int NEW_LSB   = 8;
	localparam int LOCK_BIT  = 7;
	localparam int PINLK_BIT = 6;
	localparam int PLLOK_BIT = 5;
	localparam int FAIL_BIT  = 3;
	localparam int SOSC_BIT  = 1;
	localparam int REQ_BIT   = 0;
	localparam int NOSW_BIT  = 1;

	// Unlock keys, written in turn to the key register.
	localparam logic [7:0] KEY1 = 8'h46;
	localparam logic [7:0] KEY2 = 8'h57;

	// Reset values.
	localparam logic [RW-1:0] DIV_RST    = 16'h0100;
	localparam logic [RW-1:0] ZERO_RST   = 16'h0000;

	// Interrupt event bits.
	localparam int IRQ_W   = 3;
	localparam int EV_DONE = 0;
	localparam int EV_FAIL = 1;
	localparam int EV_DENY = 2;

	// Clock source codes.
	typedef enum logic [SW-1:0] {
		SRC_FRC = 3'h0, SRC_FRCPLL = 3'h1, SRC_PRI = 3'h2, SRC_PRIPLL = 3'h3,
		SRC_SEC = 3'h4, SRC_LPRC = 3'h5, SRC_DIV16 = 3'h6, SRC_DIVN = 3'h7
	} ocs_src_t;

	// Unlock progress, Gray coded.
	typedef enum logic [1:0] {
		KY_IDLE = 2'h0, KY_ONE = 2'h1, KY_OPEN = 2'h3
	} ocs_key_t;

	// Switch sequencer states, Gray coded.
	typedef enum logic [1:0] {
		SQ_IDLE = 2'h0, SQ_WAIT = 2'h1, SQ_DONE = 2'h3
	} ocs_sq_t;

endpackage

/* inc/ocs_sw_if.sv */
/*
 * Link between the register file and the switch sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface ocs_sw_if;
	logic                 req;      // Switch requested.
	logic [ocs_pkg::SW-1:0] target; // Requested source.
	logic                 done;     // Switch complete, one cycle.
	logic [ocs_pkg::SW-1:0] done_src; // Source now running.
	modport ctl (output req, output target, input done, input done_src);
	modport seq (input req, input target, output done, output done_src);
endinterface // ocs_sw_if
`default_nettype wire

/* core/ocs_switch_seq.sv */
/*
 * Clock switch sequencer: takes a request, waits for the new source to be ready,
 * then reports completion for one cycle.
 * Assumes the ready input is synchronous to the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ocs_switch_seq (
	// Clock and reset.
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	// New source ready.
	input  wire logic src_ready_i,
	// Register side.
	ocs_sw_if.seq     sw
);
	typedef struct packed {
		ocs_pkg::ocs_sq_t       state; // Sequencer state.
		logic [ocs_pkg::SW-1:0] tgt;   // Latched target.
	} ocs_seq_st_t;

	ocs_seq_st_t st_q; // Registered state.
	ocs_seq_st_t st_d; // Next state.

	////////////////////////////////////////////////////////////////////////
	// The target is latched at the start so a later write cannot move it.
	always_comb begin
		st_d = st_q;
		case (st_q.state)
			ocs_pkg::SQ_IDLE: begin
				if (sw.req) begin
					st_d.state = ocs_pkg::SQ_WAIT;
					st_d.tgt   = sw.target;
				end
			end
			ocs_pkg::SQ_WAIT: begin
				if (src_ready_i) begin
					st_d.state = ocs_pkg::SQ_DONE;
				end
			end
			default: begin
				st_d.state = ocs_pkg::SQ_IDLE;
			end
		endcase
		if (rst_i) begin
			st_d.state = ocs_pkg::SQ_IDLE;
			st_d.tgt   = '0;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_i) begin
		st_q <= st_d;
	end

	// Completion is the done state itself, so it lasts one cycle.
	assign sw.done     = (st_q.state == ocs_pkg::SQ_DONE);
	assign sw.done_src = st_q.tgt;

	a_done_after_ready: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(st_q.state == ocs_pkg::SQ_WAIT && src_ready_i) |=> sw.done ##1 !sw.done)
		else $error("switch done did not follow ready");

endmodule // ocs_switch_seq
`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking testbench for the oscillator control and status register block.
 * Assumes the block is the only device on its Avalon-MM bus and that the bench
 * itself plays the oscillators, the configuration straps and the software.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin checked++; if ((got) !== (want)) begin n_fail++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, want); end end
module tb;
	// Bus, strap and oscillator status signals driven by the bench.
	logic        clk, rst, rd, wr, pll, fail, ready;
	logic [5:0]  addr;
	logic [31:0] wdat, rdat, q;
	logic [3:0]  be;
	logic [2:0]  init_src, sys_src, c, cur;
	logic [1:0]  mode;
	// Outputs of the block.
	logic        wreq, sosc_o, pin_o, irq;
	logic [15:0] div_o, fb_o, trim_o, auxc_o, auxfb_o, v;
	logic [15:0] exp_r [5];
	logic [5:0]  offs [5];
	int          n_fail, checked;
	int          cyc = 0;

	ocs_regs u_ocs_regs (.SYS_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
		.AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .INIT_SRC_I(init_src),
		.SW_MON_MODE_I(mode), .PLL_LOCK_I(pll), .CLK_FAIL_I(fail), .SRC_READY_I(ready),
		.SYS_SRC_O(sys_src), .CLK_DIV_O(div_o), .PLL_FB_O(fb_o), .RC_TRIM_O(trim_o),
		.AUX_CTRL_O(auxc_o), .AUX_FB_O(auxfb_o), .SEC_OSC_EN_O(sosc_o),
		.PIN_LOCK_O(pin_o), .IRQ_O(irq));

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: the whole sequence needs a few hundred cycles at most.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			$display("wrong value at %0t: run timed out", $time);
			finish_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Expected switch control word built field by field.
	function automatic logic [15:0] ctl(logic [2:0] cu, logic [2:0] nw, logic lk, logic pn,
		logic pl, logic fl, logic so, logic rq);
		return {1'b0, cu, 1'b0, nw, lk, pn, pl, 1'b0, fl, 1'b0, so, rq};
	endfunction

	// Output port that mirrors each plain data register.
	function automatic logic [15:0] outp(int i);
		case (i)
			0: return div_o;
			1: return fb_o;
			2: return trim_o;
			3: return auxc_o;
			default: return auxfb_o;
		endcase
	endfunction

	// One bus access. Waitrequest and read data are taken at the rising edge, as
	// they stood just before it; only the hang guard ends a wait that never ends.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] b);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdat <= d;
		be <= b;
		do begin
			@(posedge clk);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Read a register and compare the whole word.
	task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK(q, {16'h0, e})
	endtask

	// Unlocked write of the switch control register.
	task automatic ctl_wr(input logic [15:0] d);
		bus(1'b1, ocs_pkg::OFF_KEY, 32'h46, 4'hf);
		bus(1'b1, ocs_pkg::OFF_KEY, 32'h57, 4'hf);
		bus(1'b1, ocs_pkg::OFF_SWCTRL, {16'h0, d}, 4'hf);
	endtask

	// Power-on reset held for three cycles.
	task automatic do_reset();
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
	endtask

	// Closing report, reached from the sequence end or the hang guard.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 6'h00; wdat = 32'h0; be = 4'h0;
		mode = 2'h0; fail = 1'b0; ready = 1'b0; n_fail = 0; checked = 0;
		offs = '{ocs_pkg::OFF_DIV, ocs_pkg::OFF_PLLFB, ocs_pkg::OFF_TRIM,
			ocs_pkg::OFF_AUXC, ocs_pkg::OFF_AUXFB};
		void'($urandom(59));
		init_src = 3'($urandom);
		pll = 1'($urandom);
		do_reset();
		`CHK(sys_src, init_src)
		`CHK(div_o, ocs_pkg::DIV_RST)
		`CHK({fb_o, trim_o, auxc_o, auxfb_o, sosc_o, pin_o, irq}, 67'h0)
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(init_src, init_src, 0, 0, pll, 0, 0, 0));
		$display("test reset done");

		// Plain data registers, then a single-lane write and unmapped places.
		for (int i = 0; i < 5; i++) begin
			exp_r[i] = 16'($urandom);
			bus(1'b1, offs[i], {16'($urandom), exp_r[i]}, 4'hf);
		end
		for (int i = 0; i < 5; i++) begin
			rd_chk(offs[i], exp_r[i]);
			`CHK(outp(i), exp_r[i])
		end
		v = 16'($urandom);
		bus(1'b1, ocs_pkg::OFF_TRIM, {16'h0, v}, 4'h2);
		exp_r[2][15:8] = v[15:8];
		rd_chk(ocs_pkg::OFF_TRIM, exp_r[2]);
		bus(1'b1, 6'h24, 32'hffffffff, 4'hf);
		rd_chk(6'h24, 16'h0000);
		rd_chk(ocs_pkg::OFF_PLLFB, exp_r[1]);
		$display("test data registers done");

		// Writes without a proper unlock are refused and raise the deny event.
		c = ~init_src;
		bus(1'b1, ocs_pkg::OFF_IRQMSK, 32'h0, 4'hf);
		bus(1'b1, ocs_pkg::OFF_KEY, 32'h57, 4'hf);
		bus(1'b1, ocs_pkg::OFF_KEY, 32'h46, 4'hf);
		bus(1'b1, ocs_pkg::OFF_SWCTRL, {16'h0, ctl(0, c, 0, 0, 0, 0, 0, 1)}, 4'hf);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0)
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(init_src, init_src, 0, 0, pll, 0, 0, 0));
		rd_chk(ocs_pkg::OFF_IRQST, 16'h0004);
		rd_chk(ocs_pkg::OFF_IRQST, 16'h0000);
		bus(1'b1, ocs_pkg::OFF_IRQMSK, 32'h7, 4'hf);
		bus(1'b1, ocs_pkg::OFF_SWCTRL, {16'h0, ctl(0, c, 0, 0, 0, 0, 0, 1)}, 4'hf);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b1)
		rd_chk(ocs_pkg::OFF_IRQST, 16'h0004);
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0)
		$display("test unlock and interrupt done");

		// Switch to every source code, with the new source slow to get ready.
		cur = init_src;
		for (int k = 0; k < 8; k++) begin
			c = 3'(k);
			ctl_wr(ctl(0, c, 0, 0, 0, 0, 0, 1));
			repeat (1 + $urandom_range(4)) @(posedge clk);
			rd_chk(ocs_pkg::OFF_SWCTRL, ctl(cur, c, 0, 0, pll, 0, 0, 1));
			`CHK(sys_src, cur)
			ready <= 1'b1;
			repeat (6) @(posedge clk);
			`CHK(sys_src, c)
			rd_chk(ocs_pkg::OFF_SWCTRL, ctl(c, c, 0, 0, pll, 0, 0, 0));
			ready <= 1'b0;
			cur = c;
		end
		rd_chk(ocs_pkg::OFF_IRQST, 16'h0001);
		$display("test switching done");

		// Mode 1x: no switching and no fail monitor.
		mode <= 2'b10;
		ctl_wr(ctl(0, ~cur, 0, 0, 0, 0, 0, 1));
		ready <= 1'b1;
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(sys_src, cur)
		bus(1'b0, ocs_pkg::OFF_SWCTRL, 32'h0, 4'hf);
		`CHK(q[3], 1'b0)
		ready <= 1'b0;
		mode <= 2'b00;
		init_src <= 3'($urandom);
		do_reset();
		`CHK(sys_src, init_src)
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(init_src, init_src, 0, 0, pll, 0, 0, 0));
		$display("test monitor mode and second reset done");

		// Fail flag holds until cleared; lock bit holds against later writes.
		cur = init_src;
		@(posedge clk);
		fail <= 1'b1;
		pll <= !pll;
		@(posedge clk);
		fail <= 1'b0;
		repeat (5) @(posedge clk);
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(cur, cur, 0, 0, pll, 1, 0, 0));
		rd_chk(ocs_pkg::OFF_IRQST, 16'h0002);
		ctl_wr(ctl(0, cur, 0, 1, 0, 0, 1, 0));
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(cur, cur, 0, 1, pll, 0, 1, 0));
		`CHK({sosc_o, pin_o}, 2'b11)
		ctl_wr(ctl(0, cur, 1, 1, 0, 0, 1, 0));
		ready <= 1'b1;
		ctl_wr(ctl(0, ~cur, 0, 1, 0, 0, 1, 1));
		repeat (8) @(posedge clk);
		`CHK(sys_src, cur)
		rd_chk(ocs_pkg::OFF_SWCTRL, ctl(cur, cur, 1, 1, pll, 0, 1, 0));
		$display("test fail flag and lock done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
